/* pkg/tx_ovh_params.svh */
// Offsets, field positions, reset values and codes of the transmit format control block
`ifndef TX_OVH_PARAMS_SVH
`define TX_OVH_PARAMS_SVH

// ****************************************
// Register indexes and byte addresses
// ****************************************
`define TXF_CTRL_INDEX 8'h01
`define TXF_CTRL_ADDR 8'h04
`define TXF_PAT_ADDR 8'h10

// ****************************************
// Control register fields
// ****************************************
`define TXF_EXT_OVH_BIT 15
`define TXF_FEBE_ZERO_BIT 14
`define TXF_FEBE_ONES_BIT 13
`define TXF_ERRSEL_HI 12
`define TXF_ERRSEL_LO 10
`define TXF_ALARM_HI 9
`define TXF_ALARM_LO 4
`define TXF_OVH_HI 3
`define TXF_OVH_LO 0

// ****************************************
// Reset values
// ****************************************
`define TXF_CTRL_RESET 16'h0000
`define TXF_PAT_RESET 8'h00

// ****************************************
// Error select codes
// ****************************************
`define TXF_ERR_NONE 3'h0
`define TXF_ERR_B1 3'h1
`define TXF_ERR_B2_HI 3'h2
`define TXF_ERR_B2_MID 3'h3
`define TXF_ERR_B2_LO 3'h4
`define TXF_ERR_B3 3'h5
`define TXF_ERR_NONE2 3'h6
`define TXF_ERR_B2_ALL 3'h7

// ****************************************
// PHY type codes
// ****************************************
`define TXF_PHY_DS3 3'h2
`define TXF_PHY_E3_751 3'h3
`define TXF_PHY_E3_832 3'h4
`define TXF_PHY_E4 3'h5
`define TXF_PHY_STS1 3'h6
`define TXF_PHY_STS3C 3'h7

`endif

/* pkg/tx_ovh_pkg.sv */
// Types shared by the transmit format control block
package tx_ovh_pkg;

  // Classic Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  // Framing class derived from the PHY configuration
  typedef enum logic [7:0] {
    MODE_53_PLAIN = 8'b0000_0001,
    MODE_53_DS3 = 8'b0000_0010,
    MODE_57_EXT = 8'b0000_0100,
    MODE_57_DS3 = 8'b0000_1000,
    MODE_57_E3 = 8'b0001_0000,
    MODE_G832 = 8'b0010_0000,
    MODE_STS1 = 8'b0100_0000,
    MODE_STS3C = 8'b1000_0000
  } phy_mode_e;

  // Alarms sent toward the far end
  typedef struct packed {
    logic line_ais;
    logic line_ferf;
    logic path_yellow;
    logic path_ferf;
    logic path_ais;
    logic spe_uneq;
    logic plcp_yellow;
    logic xbit_yellow;
    logic abit_yellow;
    logic idle_code;
    logic ais;
    logic ma_timing;
    logic ma_ferf;
  } alarm_s;

  // Overhead generators switched off
  typedef struct packed {
    logic framing;
    logic b1;
    logic c1;
    logic trailer;
    logic em;
    logic ma;
    logic bip;
    logic pointer;
    logic c1c2;
  } ovh_dis_s;

  // Inversion masks for the BIP fields
  typedef struct packed {
    logic [7:0] b1;
    logic [23:0] b2;
    logic [7:0] b3;
  } err_mask_s;

endpackage

/* logic/tx_overhead_alarm_control.sv */
// Transmit format and alarm control register with mode decode for the line framer
//
// Contract
// [R01] External overhead enable in SONET and E4 modes
// [R02] All-zeros bit forces far-end block error zero
// [R03] All-ones bit forces far-end block error ones unless the all-zeros bit is also set
// [R04] Far-end block error forcing works in every mode
// [R05] Error pattern bits invert selected BIP field
// [R06] Code 001 B1 always, 101 B3 SONET
// [R07] Codes 010/011 B2 high octets, 100 low
// [R08] Code 111 all B2, 000/110 nothing
// [R09] Error select field updated after insertion
// [R10] Alarm field zero sends no alarm
// [R11] STS-3c bit 4 sends line AIS
// [R12] Overhead bits zero keep internal generation
// [R13] Overhead bit meaning depends on PHY mode
// [R14] PLCP bits: framing, B1, C1, trailer
// [R15] SONET alarm bits four to nine mapped
// [R16] Internal 57-octet DS3 alarm bits mapped
// [R17] Alarm sent while its bit stays set
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tx_ovh_params.svh"

module tx_overhead_alarm_control
  import tx_ovh_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Wishbone slave
  input wire wb_req_s wb_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // PHY configuration
  input wire logic [2:0] phy_type_in,
  input wire logic hec_align_in,
  input wire logic ext_framer_in,
  // Framer handshake
  input wire logic ins_done_in,
  // Framer controls
  output logic ext_ovh_en_out,
  output logic febe_zero_out,
  output logic febe_ones_out,
  output var err_mask_s err_mask_out,
  output var alarm_s alarm_out,
  output var ovh_dis_s ovh_dis_out
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ****************************************
  // Mode decode
  // ****************************************
  function automatic phy_mode_e mode_of(input logic [2:0] phy, input logic hec,
                                        input logic ext);
    phy_mode_e m;
    m = MODE_53_PLAIN;
    case (phy)
      `TXF_PHY_DS3: m = hec ? (ext ? MODE_53_PLAIN : MODE_53_DS3)
                            : (ext ? MODE_57_EXT : MODE_57_DS3);
      `TXF_PHY_E3_751: m = ext ? MODE_57_EXT : MODE_57_E3;
      `TXF_PHY_E3_832: m = MODE_G832;
      `TXF_PHY_E4: m = MODE_G832;
      `TXF_PHY_STS1: m = MODE_STS1;
      `TXF_PHY_STS3C: m = MODE_STS3C;
      default: m = hec ? MODE_53_PLAIN : MODE_57_EXT;
    endcase
    return m;
  endfunction

  function automatic logic is_sonet(input phy_mode_e m);
    return (m == MODE_STS1) || (m == MODE_STS3C);
  endfunction

  function automatic logic is_plcp(input phy_mode_e m);
    return (m == MODE_57_EXT) || (m == MODE_57_DS3) || (m == MODE_57_E3);
  endfunction

  phy_mode_e mode;
  assign mode = mode_of(phy_type_in, hec_align_in, ext_framer_in);

  // ****************************************
  // Register bus and storage
  // ****************************************
  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [7:0] pat_reg;
  logic [7:0] pat_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic req;
  logic wr_now;

  assign req = wb_in.cyc & wb_in.stb;
  assign wr_now = req & wb_in.we & ack_reg;

  always_comb begin
    ctrl_next = ctrl_reg;
    pat_next = pat_reg;
    ack_next = req & ~ack_reg;
    rdata_next = 32'h0000_0000;
    if (ins_done_in && ctrl_reg[`TXF_ERRSEL_HI:`TXF_ERRSEL_LO] != `TXF_ERR_NONE) begin
      ctrl_next[`TXF_ERRSEL_HI:`TXF_ERRSEL_LO] = `TXF_ERR_NONE; // R09
    end
    if (wr_now && wb_in.adr == `TXF_CTRL_ADDR) begin
      if (wb_in.sel[0]) begin
        ctrl_next[7:0] = wb_in.dat[7:0];
      end
      if (wb_in.sel[1]) begin
        ctrl_next[15:8] = wb_in.dat[15:8];
      end
    end
    if (wr_now && wb_in.adr == `TXF_PAT_ADDR && wb_in.sel[0]) begin
      pat_next = wb_in.dat[7:0];
    end
    if (req && !ack_reg && !wb_in.we) begin
      case (wb_in.adr)
        `TXF_CTRL_ADDR: rdata_next = {16'h0000, ctrl_reg};
        `TXF_PAT_ADDR: rdata_next = {24'h00_0000, pat_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ctrl_reg <= `TXF_CTRL_RESET;
      pat_reg <= `TXF_PAT_RESET;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      pat_reg <= pat_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign wb_ack_out = ack_reg;
  assign wb_dat_out = rdata_reg;

  // ****************************************
  // Framer control decode
  // ****************************************
  logic [2:0] errsel;
  logic [5:0] alm;
  logic [3:0] ovh;
  logic ext_ovh_next;
  logic febe_zero_next;
  logic febe_ones_next;
  err_mask_s mask_next;
  alarm_s alarm_next;
  ovh_dis_s ovh_next;
  logic ext_ovh_reg;
  logic febe_zero_reg;
  logic febe_ones_reg;
  err_mask_s mask_reg;
  alarm_s alarm_reg;
  ovh_dis_s ovh_reg;

  assign errsel = ctrl_reg[`TXF_ERRSEL_HI:`TXF_ERRSEL_LO];
  assign alm = ctrl_reg[`TXF_ALARM_HI:`TXF_ALARM_LO];
  assign ovh = ctrl_reg[`TXF_OVH_HI:`TXF_OVH_LO];

  always_comb begin
    ext_ovh_next = ctrl_reg[`TXF_EXT_OVH_BIT] &
                   (is_sonet(mode) | (phy_type_in == `TXF_PHY_E4)); // R01
    febe_zero_next = ctrl_reg[`TXF_FEBE_ZERO_BIT]; // R02 R04
    febe_ones_next = ctrl_reg[`TXF_FEBE_ONES_BIT] & ~ctrl_reg[`TXF_FEBE_ZERO_BIT]; // R03 R04
    mask_next = '0;
    case (errsel)
      `TXF_ERR_B1: mask_next.b1 = pat_reg; // R05 R06
      `TXF_ERR_B2_HI: mask_next.b2[23:16] = (mode == MODE_STS3C) ? pat_reg : 8'h00; // R07
      `TXF_ERR_B2_MID: mask_next.b2[15:8] = (mode == MODE_STS3C) ? pat_reg : 8'h00; // R07
      `TXF_ERR_B2_LO: mask_next.b2[7:0] = is_sonet(mode) ? pat_reg : 8'h00; // R07
      `TXF_ERR_B3: mask_next.b3 = is_sonet(mode) ? pat_reg : 8'h00; // R06
      `TXF_ERR_B2_ALL: mask_next.b2 = (mode == MODE_STS3C) ? {3{pat_reg}} : 24'h00_0000; // R08
      default: mask_next = '0; // R08
    endcase
    alarm_next = '0; // R10 R17
    case (mode)
      MODE_STS1, MODE_STS3C: begin
        alarm_next.line_ais = alm[0]; // R11 R15
        alarm_next.line_ferf = alm[1]; // R15
        alarm_next.path_yellow = alm[2];
        alarm_next.path_ferf = alm[3];
        alarm_next.path_ais = alm[4];
        alarm_next.spe_uneq = alm[5];
      end
      MODE_57_EXT: alarm_next.plcp_yellow = alm[3];
      MODE_57_DS3: begin
        alarm_next.plcp_yellow = alm[3]; // R16
        alarm_next.xbit_yellow = alm[2];
        alarm_next.idle_code = alm[1];
        alarm_next.ais = alm[0];
      end
      MODE_57_E3: begin
        alarm_next.plcp_yellow = alm[3];
        alarm_next.abit_yellow = alm[2];
        alarm_next.ais = alm[0];
      end
      MODE_G832: begin
        alarm_next.ma_timing = alm[2];
        alarm_next.ma_ferf = alm[1];
        alarm_next.ais = alm[0];
      end
      MODE_53_DS3: begin
        alarm_next.xbit_yellow = alm[2];
        alarm_next.idle_code = alm[1];
        alarm_next.ais = alm[0];
      end
      default: alarm_next = '0;
    endcase
    ovh_next = '0; // R12
    if (is_plcp(mode)) begin
      ovh_next.framing = ovh[3]; // R13 R14
      ovh_next.b1 = ovh[2];
      ovh_next.c1 = ovh[1];
      ovh_next.trailer = ovh[0];
    end else if (mode == MODE_G832) begin
      ovh_next.framing = ovh[3]; // R13
      ovh_next.em = ovh[2];
      ovh_next.ma = ovh[1];
    end else if (is_sonet(mode)) begin
      ovh_next.framing = ovh[3]; // R13
      ovh_next.bip = ovh[2];
      ovh_next.pointer = ovh[1];
      ovh_next.c1c2 = ovh[0];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ext_ovh_reg <= 1'b0;
      febe_zero_reg <= 1'b0;
      febe_ones_reg <= 1'b0;
      mask_reg <= '0;
      alarm_reg <= '0;
      ovh_reg <= '0;
    end else begin
      ext_ovh_reg <= ext_ovh_next;
      febe_zero_reg <= febe_zero_next;
      febe_ones_reg <= febe_ones_next;
      mask_reg <= mask_next;
      alarm_reg <= alarm_next;
      ovh_reg <= ovh_next;
    end
  end

  assign ext_ovh_en_out = ext_ovh_reg;
  assign febe_zero_out = febe_zero_reg;
  assign febe_ones_out = febe_ones_reg;
  assign err_mask_out = mask_reg;
  assign alarm_out = alarm_reg;
  assign ovh_dis_out = ovh_reg;

  // ****************************************
  // Checks
  // ****************************************
  a_ack_single_pulse: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg)
    wb_ack_out |=> !wb_ack_out)
    else $error("ack held two cycles");

  a_ext_ovh_mode: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg) // R01
    ext_ovh_en_out |-> $past(ctrl_reg[`TXF_EXT_OVH_BIT]) && $past(phy_type_in) >= `TXF_PHY_E4)
    else $error("external overhead outside SONET or E4");

  a_febe_forcing: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg) // R02
    ctrl_reg[`TXF_FEBE_ZERO_BIT] ##1 ctrl_reg[`TXF_FEBE_ZERO_BIT] |-> febe_zero_out && !febe_ones_out)
    else $error("far-end error forcing wrong");

  a_febe_ones: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg) // R03
    ctrl_reg[`TXF_FEBE_ONES_BIT] && !ctrl_reg[`TXF_FEBE_ZERO_BIT] |=> febe_ones_out)
    else $error("all-ones forcing missing");

  a_b1_mask: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg) // R06
    errsel == `TXF_ERR_B1 |=> err_mask_out.b1 == $past(pat_reg) && err_mask_out.b3 == 8'h00)
    else $error("B1 mask wrong");

  a_b2_mode_gate: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg) // R07
    mode != MODE_STS3C |=> err_mask_out.b2[23:8] == 16'h0000)
    else $error("B2 high octets errored outside STS-3c");

  a_no_err_codes: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg) // R08
    errsel == `TXF_ERR_NONE || errsel == `TXF_ERR_NONE2 |=> err_mask_out == '0)
    else $error("error inserted for idle code");

  a_errsel_clear: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg) // R09
    ins_done_in && !wr_now && errsel != `TXF_ERR_NONE |=> errsel == `TXF_ERR_NONE ##1
    err_mask_out == '0)
    else $error("error select not updated after insertion");

  a_alarm_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg) // R10
    alm == 6'h00 [*2] |-> alarm_out == '0)
    else $error("alarm sent with field clear");

  a_line_ais: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg) // R11
    mode == MODE_STS3C && alm[0] |=> alarm_out.line_ais)
    else $error("line AIS missing in STS-3c");

  a_plcp_ovh: assert property (@(posedge core_clk_in) disable iff (!rst_n_reg) // R14
    is_plcp(mode) |=> ovh_dis_out.b1 == $past(ovh[2]) && ovh_dis_out.bip == 1'b0)
    else $error("PLCP overhead disable wrong");

endmodule // tx_overhead_alarm_control
`default_nettype wire

/* sim/framer_model.sv */
// Line framer stand-in that acknowledges BIP error insertion
`timescale 1ns/1ps
`default_nettype none

module framer_model
  import tx_ovh_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Control from bench
  input wire logic en_in,
  input wire logic [1:0] lag_in,
  // Masks from the block
  input wire err_mask_s mask_in,
  // Insertion done pulse
  output logic ins_done_out
);
  logic [1:0] cnt_reg;
  logic hold_reg;

  // ****************************************
  // Insert after a lag, then wait for clear
  // ****************************************
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_reg <= 2'h0;
      hold_reg <= 1'b0;
      ins_done_out <= 1'b0;
    end else begin
      ins_done_out <= 1'b0;
      if (hold_reg) begin
        hold_reg <= (mask_in != '0);
      end else if (en_in && mask_in != '0) begin
        if (cnt_reg == lag_in) begin
          ins_done_out <= 1'b1;
          hold_reg <= 1'b1;
          cnt_reg <= 2'h0;
        end else begin
          cnt_reg <= cnt_reg + 2'h1;
        end
      end
    end
  end
endmodule // framer_model

`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the transmit format control block
`timescale 1ns/1ps
`default_nettype none
`include "tx_ovh_params.svh"

module tb_top;
  import tx_ovh_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  wb_req_s wb = '0;
  logic [31:0] rdat;
  logic ack, ins_done, ext_ovh, fz, fo;
  logic [2:0] phy = 3'h0;
  logic hec = 1'b0;
  logic extf = 1'b0;
  logic fr_en = 1'b0;
  logic [1:0] lag = 2'h0;
  err_mask_s mask;
  alarm_s alarm;
  ovh_dis_s ovh;
  integer fail_count = 0;
  integer n_compared = 0;
  integer seed = 28449;
  integer t, c, i;
  integer dsb[4] = '{2, 3, 5, 6};
  logic [15:0] ctrl_m;
  logic [7:0] pat_m;

  always #50 clk = ~clk;

  tx_overhead_alarm_control dut_u (.core_clk_in(clk), .nrst_in(nrst), .wb_in(wb),
    .wb_dat_out(rdat), .wb_ack_out(ack), .phy_type_in(phy), .hec_align_in(hec),
    .ext_framer_in(extf), .ins_done_in(ins_done), .ext_ovh_en_out(ext_ovh),
    .febe_zero_out(fz), .febe_ones_out(fo), .err_mask_out(mask), .alarm_out(alarm),
    .ovh_dis_out(ovh));

  framer_model fr_u (.clk_in(clk), .nrst_in(nrst), .en_in(fr_en), .lag_in(lag),
    .mask_in(mask), .ins_done_out(ins_done));

  // ****************************************
  // Reference and helpers
  // ****************************************
  function automatic err_mask_s exp_mask(input logic [2:0] k, input logic [7:0] p,
                                         input logic [2:0] y);
    err_mask_s m = '0;
    case (k)
      3'h1: m.b1 = p;
      3'h2: if (y == 3'h7) m.b2[23:16] = p;
      3'h3: if (y == 3'h7) m.b2[15:8] = p;
      3'h4: if (y >= 3'h6) m.b2[7:0] = p;
      3'h5: if (y >= 3'h6) m.b3 = p;
      3'h7: if (y == 3'h7) m.b2 = {3{p}};
      default: ;
    endcase
    return m;
  endfunction

  // Expected alarm and overhead disables, packed as alarm then overhead
  function automatic logic [21:0] exp_fmt(input logic [2:0] y, input logic h, input logic x,
                                          input logic [9:0] v);
    logic [12:0] a;
    logic [8:0] o;
    integer k;
    a = 13'h0000;
    o = 9'h000;
    if (y >= 3'h6) begin
      for (k = 0; k < 6; k++) a[12 - k] = v[4 + k];
      o = {v[3], 5'h00, v[2:0]};
    end else if (y >= 3'h4) begin
      a[2:0] = {v[4], v[6], v[5]};
      o = {v[3], 3'h0, v[2:1], 3'h0};
    end else if (y == 3'h3 || !h) begin
      a[6] = v[7];
      o = {v[3:0], 5'h00};
      if (!x && y == 3'h2) {a[5], a[3], a[2]} = v[6:4];
      if (!x && y == 3'h3) {a[4], a[2]} = {v[6], v[4]};
    end else if (y == 3'h2 && !x) begin
      {a[5], a[3], a[2]} = v[6:4];
    end
    return {a, o};
  endfunction

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    integer n;
    n = 0;
    @(posedge clk);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h3, dat: d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    wb <= '0;
    if (n >= 20) begin
      fail_count++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    xfer(1'b1, a, {16'h0000, d}, q);
    if (a == `TXF_CTRL_ADDR) ctrl_m = d;
    if (a == `TXF_PAT_ADDR) pat_m = d[7:0];
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    check(q, e);
  endtask

  task automatic cfg(input logic [2:0] y, input logic h, input logic x);
    @(posedge clk);
    phy <= y;
    hec <= h;
    extf <= x;
  endtask

  task automatic rnd_pat;
    wr(`TXF_PAT_ADDR, {8'h00, 8'($random(seed)) | 8'h01});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`TXF_CTRL_ADDR, 32'h0000_0000);
    rd(`TXF_PAT_ADDR, 32'h0000_0000);
    check(64'(alarm) | 64'(ovh), 64'h0000_0000_0000_0000);
    wr(8'h3c, 16'hffff);
    rd(8'h3c, 32'h0000_0000);
    $display("test reset done");
    for (t = 5; t < 8; t++) begin
      cfg(3'(t), 1'b1, 1'b0);
      for (c = 0; c < 8; c++) begin
        rnd_pat();
        wr(`TXF_CTRL_ADDR, 16'(c) << 10);
        check(64'(mask), 64'(exp_mask(3'(c), pat_m, 3'(t))));
      end
    end
    $display("test error select done");
    for (t = 2; t < 8; t++) begin
      cfg(3'(t), t >= 4, 1'b0);
      for (c = 0; c < 8; c++) begin
        wr(`TXF_CTRL_ADDR, 16'(c) << 13);
        check({ext_ovh, fz, fo}, {t >= 5 && c[2], c[1], c[0] && !c[1]});
      end
    end
    $display("test febe done");
    cfg(3'h7, 1'b1, 1'b0);
    for (c = 0; c < 6; c++) begin
      wr(`TXF_CTRL_ADDR, 16'h0010 << c);
      check(64'(alarm), 64'(13'h1000 >> c));
    end
    repeat (20) @(posedge clk);
    check(64'(alarm), 64'(13'h0080));
    wr(`TXF_CTRL_ADDR, 16'h0000);
    check(64'(alarm), 64'h0000_0000_0000_0000);
    cfg(3'h2, 1'b0, 1'b0);
    for (c = 0; c < 4; c++) begin
      wr(`TXF_CTRL_ADDR, 16'h0010 << c);
      check(64'(alarm), 64'(13'h0001 << dsb[c]));
    end
    $display("test alarms done");
    for (c = 0; c < 16; c++) begin
      wr(`TXF_CTRL_ADDR, 16'(c));
      check(64'(ovh), 64'(c) << 5);
    end
    cfg(3'h0, 1'b1, 1'b0);
    wr(`TXF_CTRL_ADDR, 16'h000f);
    check(64'(ovh), 64'h0000_0000_0000_0000);
    $display("test overhead done");
    for (t = 0; t < 32; t++) begin
      cfg(3'(t), t[3], t[4]);
      wr(`TXF_CTRL_ADDR, 16'($random(seed)) & 16'h03ff);
      check({alarm, ovh}, exp_fmt(3'(t), t[3], t[4], ctrl_m[9:0]));
    end
    $display("test modes done");
    cfg(3'h7, 1'b1, 1'b0);
    for (c = 0; c < 4; c++) begin
      rnd_pat();
      wr(`TXF_CTRL_ADDR, 16'h8000 | (16'(c[0] ? 7 : 1 + 3 * c[1]) << 10));
      check(64'(mask), 64'(exp_mask(ctrl_m[12:10], pat_m, 3'h7)));
      @(posedge clk);
      fr_en <= 1'b1;
      lag <= 2'($random(seed));
      for (i = 0; i < 20 && ins_done !== 1'b1; i++) @(posedge clk);
      if (i >= 20) begin
        fail_count++;
        finish_test();
      end
      repeat (3) @(posedge clk);
      fr_en <= 1'b0;
      rd(`TXF_CTRL_ADDR, 32'h0000_8000);
      check(64'(mask), 64'h0000_0000_0000_0000);
    end
    $display("test insertion done");
    finish_test();
  end
endmodule // tb_top

`default_nettype wire
